// File: hw/uart_regs_defines.svh
// Offsets, field positions and reset values for the serial channel register map
`ifndef UART_REGS_DEFINES_SVH
`define UART_REGS_DEFINES_SVH
`define OFS_DATA 3'h0
`define OFS_INT_ENABLE 3'h1
`define OFS_INT_IDENT 3'h2
`define OFS_LINE_CTRL 3'h3
`define OFS_MODEM_CTRL 3'h4
`define OFS_LINE_STATUS 3'h5
`define OFS_MODEM_STATUS 3'h6
`define OFS_SPARE 3'h7
`define LATCH_ACCESS_BIT 7
`define FIFO_ENABLE_BIT 0
`define FIFO_RX_CLEAR_BIT 1
`define FIFO_TX_CLEAR_BIT 2
`define AUX_TWO_BIT 3
`define INT_IDENT_RESET 8'h01
`define LINE_STATUS_RESET 8'h60
`define INT_ENABLE_MASK 8'h0F
`define MODEM_CTRL_MASK 8'h1F
`define FIFO_CTRL_MASK 8'hC1
`define FRAME_LAST 4'h8
`define SRC_LINE 3'h3
`define SRC_RX 3'h2
`define SRC_TX 3'h1
`define SRC_MODEM 3'h0
`endif

// File: hw/uart_regs_pkg.sv
// Types for the serial channel register map
package uart_regs_pkg;
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} host_req_t;
	typedef struct packed {
		logic break_flag;
		logic framing_flag;
		logic parity_flag;
		logic overrun;
	} rx_err_t;
	typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} tx_state_t;
endpackage : uart_regs_pkg

// File: hw/uart_channel_regs.sv
// Register map and minimal serial datapath of one serial channel
`timescale 1ns/1ps
`include "uart_regs_defines.svh"
module uart_channel_regs (
	input wire logic clk,
	input wire logic sys_rst,
	input wire uart_regs_pkg::host_req_t host_req,
	output logic [7:0] rdata,
	input wire logic xt_mode,
	input wire logic rx_bit,
	input wire logic [3:0] modem_in,
	output logic tx_bit,
	output logic irq,
	output logic [15:0] baud_div
);
	// Pin synchroniser stages
	logic rx_s1_reg;
	logic rx_s2_reg;
	logic [3:0] mi_s1_reg;
	logic [3:0] mi_s2_reg;
	logic [3:0] mi_old_reg;
	// Host-visible registers
	logic [7:0] int_enable_reg;
	logic [7:0] line_ctrl_reg;
	logic [7:0] modem_ctrl_reg;
	logic [7:0] spare_reg;
	logic [7:0] div_low_reg;
	logic [7:0] div_high_reg;
	logic [7:0] fifo_ctrl_reg;
	// Data path state
	logic [7:0] tx_hold_reg;
	logic [7:0] rx_buf_reg;
	logic [7:0] tx_shift_reg;
	logic [7:0] rx_sh_reg;
	logic tx_hold_full_reg;
	logic rx_valid_reg;
	logic fifo_err_reg;
	logic [3:0] modem_delta_reg;
	uart_regs_pkg::rx_err_t err_reg;
	uart_regs_pkg::tx_state_t tx_state_reg;
	logic [3:0] tx_cnt_reg;
	logic [3:0] rx_cnt_reg;
	logic rx_busy_reg;
	logic tx_empty_pend_reg;
	// Assembled read values
	logic [7:0] ident_val;
	logic [7:0] status_val;
	// Decode and status wires
	logic latch_access_sel;
	logic fifo_on;
	logic wr_data;
	logic rd_data;
	logic fifo_ctrl_wr;
	logic rd_ident;
	logic rd_status;
	logic rd_modem;
	logic tx_load;
	logic rx_done;
	logic tx_idle;
	logic tx_holding_empty;
	logic tx_all_empty;
	logic [2:0] src;
	logic pend;
	// Address decode
	assign latch_access_sel = line_ctrl_reg[`LATCH_ACCESS_BIT];
	assign fifo_on = fifo_ctrl_reg[`FIFO_ENABLE_BIT];
	assign wr_data = host_req.wr && host_req.addr == `OFS_DATA && !latch_access_sel;
	assign rd_data = host_req.rd && host_req.addr == `OFS_DATA && !latch_access_sel;
	assign fifo_ctrl_wr = host_req.wr && host_req.addr == `OFS_INT_IDENT;
	assign rd_ident = host_req.rd && host_req.addr == `OFS_INT_IDENT;
	assign rd_status = host_req.rd && host_req.addr == `OFS_LINE_STATUS;
	assign rd_modem = host_req.rd && host_req.addr == `OFS_MODEM_STATUS;
	assign baud_div = {div_high_reg, div_low_reg};
	// Transmitter status
	assign tx_idle = tx_state_reg == uart_regs_pkg::TX_IDLE;
	assign tx_holding_empty = !tx_hold_full_reg;
	assign tx_all_empty = tx_idle && (xt_mode || tx_holding_empty);
	// Pin synchronisers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rx_s1_reg <= 1'b1;
			rx_s2_reg <= 1'b1;
			mi_s1_reg <= 4'h0;
			mi_s2_reg <= 4'h0;
			mi_old_reg <= 4'h0;
		end else begin
			rx_s1_reg <= rx_bit;
			rx_s2_reg <= rx_s1_reg;
			mi_s1_reg <= modem_in;
			mi_s2_reg <= mi_s1_reg;
			mi_old_reg <= mi_s2_reg;
		end
	end
	// Host-writable registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			int_enable_reg <= 8'h00;
			line_ctrl_reg <= 8'h00;
			modem_ctrl_reg <= 8'h00;
			spare_reg <= 8'h00;
			div_low_reg <= 8'h00;
			div_high_reg <= 8'h00;
			fifo_ctrl_reg <= 8'h00;
		end else if (host_req.wr) begin
			unique case (host_req.addr)
				`OFS_DATA: begin
					if (latch_access_sel) div_low_reg <= host_req.wdata;
				end
				`OFS_INT_ENABLE: begin
					if (latch_access_sel) div_high_reg <= host_req.wdata;
					else int_enable_reg <= host_req.wdata & `INT_ENABLE_MASK;
				end
				`OFS_INT_IDENT: begin
					fifo_ctrl_reg <= host_req.wdata & `FIFO_CTRL_MASK;
				end
				`OFS_LINE_CTRL: begin
					line_ctrl_reg <= host_req.wdata;
				end
				`OFS_MODEM_CTRL: begin
					modem_ctrl_reg <= host_req.wdata & `MODEM_CTRL_MASK;
				end
				`OFS_SPARE: begin
					if (!xt_mode) spare_reg <= host_req.wdata;
				end
				default: ;
			endcase
		end
	end
	// Transmitter, one bit per clock
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_hold_reg <= 8'h00;
			tx_hold_full_reg <= 1'b0;
			tx_shift_reg <= 8'h00;
			tx_cnt_reg <= 4'h0;
			tx_state_reg <= uart_regs_pkg::TX_IDLE;
			tx_bit <= 1'b1;
		end else begin
			if (wr_data) begin
				tx_hold_reg <= host_req.wdata;
				tx_hold_full_reg <= 1'b1;
			end else if (tx_load) begin
				tx_hold_full_reg <= 1'b0;
			end
			if (fifo_ctrl_wr && host_req.wdata[`FIFO_TX_CLEAR_BIT]) begin
				tx_hold_full_reg <= 1'b0;
			end
			unique case (tx_state_reg)
				uart_regs_pkg::TX_IDLE: begin
					tx_bit <= 1'b1;
					if (tx_load) begin
						tx_shift_reg <= tx_hold_reg;
						tx_cnt_reg <= 4'h0;
						tx_bit <= 1'b0;
						tx_state_reg <= uart_regs_pkg::TX_SHIFT;
					end
				end
				uart_regs_pkg::TX_SHIFT: begin
					tx_cnt_reg <= tx_cnt_reg + 4'h1;
					if (tx_cnt_reg == `FRAME_LAST) begin
						tx_bit <= 1'b1;
						tx_state_reg <= uart_regs_pkg::TX_IDLE;
					end else begin
						tx_bit <= tx_shift_reg[0];
						tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
					end
				end
			endcase
		end
	end
	// A write in the same cycle holds the load off by one clock
	assign tx_load = tx_idle && tx_hold_full_reg && !wr_data;
	// Receiver, one bit per clock
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rx_busy_reg <= 1'b0;
			rx_cnt_reg <= 4'h0;
			rx_sh_reg <= 8'h00;
		end else if (!rx_busy_reg) begin
			rx_cnt_reg <= 4'h0;
			if (!rx_s2_reg) begin
				rx_busy_reg <= 1'b1;
			end
		end else begin
			rx_cnt_reg <= rx_cnt_reg + 4'h1;
			if (rx_cnt_reg == `FRAME_LAST) begin
				rx_busy_reg <= 1'b0;
			end else begin
				rx_sh_reg <= {rx_s2_reg, rx_sh_reg[7:1]};
			end
		end
	end
	assign rx_done = rx_busy_reg && rx_cnt_reg == `FRAME_LAST;
	// Receive buffer and line status flags, set wins over clear
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rx_buf_reg <= 8'h00;
			rx_valid_reg <= 1'b0;
			err_reg <= '0;
			fifo_err_reg <= 1'b0;
		end else begin
			if (rd_status) begin
				err_reg <= '0;
				fifo_err_reg <= 1'b0;
			end
			if (rx_done) begin
				rx_buf_reg <= rx_sh_reg;
				rx_valid_reg <= 1'b1;
				if (rx_valid_reg) begin
					err_reg.overrun <= 1'b1;
				end
				if (!rx_s2_reg) begin
					err_reg.framing_flag <= 1'b1;
					if (rx_sh_reg == 8'h00) begin
						err_reg.break_flag <= 1'b1;
					end
					fifo_err_reg <= fifo_on;
				end
			end else if (rd_data || (fifo_ctrl_wr && host_req.wdata[`FIFO_RX_CLEAR_BIT])) begin
				rx_valid_reg <= 1'b0;
			end
		end
	end
	// Modem deltas, sticky until the modem status read
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			modem_delta_reg <= 4'h0;
		end else begin
			modem_delta_reg <= (rd_modem ? 4'h0 : modem_delta_reg) | (mi_s2_reg ^ mi_old_reg);
		end
	end
	// Transmit-empty interrupt latch
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_empty_pend_reg <= 1'b0;
		end else if (tx_load) begin
			tx_empty_pend_reg <= 1'b1;
		end else if (wr_data || (rd_ident && src == `SRC_TX)) begin
			tx_empty_pend_reg <= 1'b0;
		end
	end
	// Interrupt source priority
	always_comb begin
		pend = 1'b1;
		src = `SRC_MODEM;
		if (int_enable_reg[2] && (|err_reg)) begin
			src = `SRC_LINE;
		end else if (int_enable_reg[0] && rx_valid_reg) begin
			src = `SRC_RX;
		end else if (int_enable_reg[1] && tx_empty_pend_reg) begin
			src = `SRC_TX;
		end else if (int_enable_reg[3] && (|modem_delta_reg)) begin
			src = `SRC_MODEM;
		end else begin
			pend = 1'b0;
		end
	end
	// Second auxiliary bit gates the request internally, no pin
	assign irq = pend && modem_ctrl_reg[`AUX_TWO_BIT];
	always_comb begin
		ident_val = `INT_IDENT_RESET;
		if (pend) begin
			ident_val = {4'h0, src, 1'b0};
		end
		if (fifo_on) begin
			ident_val[7:6] = 2'h3;
		end else begin
			ident_val[3] = 1'b0;
		end
	end
	always_comb begin
		status_val = {fifo_err_reg & fifo_on,
			tx_all_empty,
			tx_holding_empty,
			err_reg.break_flag,
			err_reg.framing_flag,
			err_reg.parity_flag,
			err_reg.overrun,
			rx_valid_reg};
	end
	// Read data, one cycle after strobe
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata <= 8'h00;
		end else if (host_req.rd) begin
			unique case (host_req.addr)
				`OFS_DATA: rdata <= latch_access_sel ? div_low_reg : rx_buf_reg;
				`OFS_INT_ENABLE: rdata <= latch_access_sel ? div_high_reg : int_enable_reg;
				`OFS_INT_IDENT: rdata <= ident_val;
				`OFS_LINE_CTRL: rdata <= line_ctrl_reg;
				`OFS_MODEM_CTRL: rdata <= modem_ctrl_reg;
				`OFS_LINE_STATUS: rdata <= status_val;
				`OFS_MODEM_STATUS: rdata <= {mi_s2_reg, modem_delta_reg};
				`OFS_SPARE: rdata <= xt_mode ? 8'h00 : spare_reg;
				default: rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end
	// Checks on the register map
	reset_ident_a: assert property (@(posedge clk)
		$fell(sys_rst) |-> ident_val == `INT_IDENT_RESET) else $error("ident not idle after reset");
	reset_status_a: assert property (@(posedge clk)
		$fell(sys_rst) |-> status_val == `LINE_STATUS_RESET) else $error("status wrong after reset");
	nofifo_bits_a: assert property (@(posedge clk) disable iff (sys_rst)
		!fifo_on |-> ident_val[7:6] == 2'h0 && !ident_val[3] && !status_val[7]) else $error("fifo bits set");
	divisor_read_a: assert property (@(posedge clk) disable iff (sys_rst)
		host_req.rd && host_req.addr == `OFS_DATA && latch_access_sel |=> rdata == $past(div_low_reg))
		else $error("divisor low read wrong");
	rx_read_a: assert property (@(posedge clk) disable iff (sys_rst)
		rd_data |=> rdata == $past(rx_buf_reg)) else $error("rx buffer read wrong");
	ident_pend_a: assert property (@(posedge clk) disable iff (sys_rst)
		pend |-> !ident_val[0]) else $error("pending bit wrong");
	enable_upper_a: assert property (@(posedge clk) disable iff (sys_rst)
		int_enable_reg[7:4] == 4'h0) else $error("enable upper bits set");
	xt_spare_a: assert property (@(posedge clk) disable iff (sys_rst)
		host_req.rd && host_req.addr == `OFS_SPARE && xt_mode |=> rdata == 8'h00) else $error("spare present");
	tx_lsb_a: assert property (@(posedge clk) disable iff (sys_rst)
		tx_load |=> !tx_bit ##1 tx_bit == $past(tx_hold_reg[0], 2)) else $error("lsb not first");
	dma_none_a: assert property (@(posedge clk) disable iff (sys_rst)
		!fifo_ctrl_reg[3]) else $error("dma bit stored");
	xt_empty_a: assert property (@(posedge clk) disable iff (sys_rst)
		xt_mode && tx_idle |-> status_val[6]) else $error("empty flag missing");
	hold_load_a: assert property (@(posedge clk) disable iff (sys_rst)
		wr_data |=> tx_hold_reg == $past(host_req.wdata) && tx_hold_full_reg) else $error("holding not loaded");
	// Main scenarios
	tx_cov_c: cover property (@(posedge clk) tx_load);
	rx_cov_c: cover property (@(posedge clk) rx_done);
	irq_cov_c: cover property (@(posedge clk) irq);
	modem_cov_c: cover property (@(posedge clk) |modem_delta_reg);
endmodule : uart_channel_regs

// File: test/serial_peer.sv
// Serial line peer: sends and captures 8N1 frames, one bit per clock
`timescale 1ns/1ps
module serial_peer (
	input wire logic clk,
	input wire logic tx_bit,
	input wire logic go,
	input wire logic [7:0] din,
	output logic rx_bit,
	output logic [7:0] got
);
	logic [9:0] sh_reg = 10'h3FF;
	logic [3:0] cnt_reg = 4'h0;
	assign rx_bit = sh_reg[0];
	always_ff @(posedge clk) begin
		if (go) begin
			sh_reg <= {1'b1, din, 1'b0};
		end else begin
			sh_reg <= {1'b1, sh_reg[9:1]};
		end
	end
	always_ff @(posedge clk) begin
		if (cnt_reg == 4'h0) begin
			if (tx_bit == 1'b0) cnt_reg <= 4'h8;
		end else begin
			got <= {tx_bit, got[7:1]};
			cnt_reg <= cnt_reg - 4'h1;
		end
	end
endmodule : serial_peer

// File: test/uart_channel_regs_bench.sv
// Self-checking bench for the serial channel register map
`timescale 1ns/1ps
`include "uart_regs_defines.svh"
module uart_channel_regs_bench;
	logic clk;
	logic sys_rst;
	uart_regs_pkg::host_req_t host_req;
	logic [7:0] rdata;
	logic xt_mode;
	logic rx_bit;
	logic [3:0] modem_in;
	logic tx_bit;
	logic irq;
	logic [15:0] baud_div;
	logic go;
	logic [7:0] din;
	logic [7:0] got;
	logic [7:0] v;
	logic [31:0] seed;
	int miscompares;
	int samples_checked;
	uart_channel_regs DUT (.clk(clk), .sys_rst(sys_rst), .host_req(host_req), .rdata(rdata),
		.xt_mode(xt_mode), .rx_bit(rx_bit), .modem_in(modem_in), .tx_bit(tx_bit), .irq(irq),
		.baud_div(baud_div));
	serial_peer peer (.clk(clk), .tx_bit(tx_bit), .go(go), .din(din), .rx_bit(rx_bit), .got(got));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		host_req <= {a, d, 1'b1, 1'b0};
		@(posedge clk);
		host_req <= '0;
		#1;
	endtask : wr
	task automatic rc(input logic [2:0] a, input logic [7:0] exp);
		@(posedge clk);
		host_req <= {a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		host_req <= '0;
		#1;
		chk(rdata, exp);
	endtask : rc
	task automatic send(input logic [7:0] b);
		@(posedge clk);
		din <= b;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		repeat (16) @(posedge clk);
		#1;
	endtask : send
	task automatic finish_test();
		$display("Checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : finish_test
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		#1000000;
		miscompares++;
		finish_test();
	end
	initial begin
		sys_rst = 1'b1;
		host_req = '0;
		xt_mode = 1'b0;
		modem_in = 4'h0;
		go = 1'b0;
		din = 8'h00;
		seed = 32'h0001215D;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		rc(`OFS_INT_IDENT, 8'h01);
		rc(`OFS_LINE_STATUS, 8'h60);
		rc(`OFS_MODEM_STATUS, 8'h00);
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			wr(`OFS_SPARE, seed[7:0]);
			rc(`OFS_SPARE, seed[7:0]);
		end
		xt_mode <= 1'b1;
		wr(`OFS_SPARE, 8'h5A);
		rc(`OFS_SPARE, 8'h00);
		xt_mode <= 1'b0;
		wr(`OFS_INT_ENABLE, 8'hFF);
		rc(`OFS_INT_ENABLE, 8'h0F);
		wr(`OFS_INT_ENABLE, 8'h00);
		seed = xs(seed);
		wr(`OFS_LINE_CTRL, 8'h80);
		wr(`OFS_DATA, seed[7:0]);
		wr(`OFS_INT_ENABLE, seed[15:8]);
		chk(baud_div, seed[15:0]);
		rc(`OFS_DATA, seed[7:0]);
		rc(`OFS_INT_ENABLE, seed[15:8]);
		wr(`OFS_LINE_CTRL, 8'h03);
		rc(`OFS_LINE_CTRL, 8'h03);
		rc(`OFS_INT_ENABLE, 8'h00);
		for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			v = (i == 0) ? 8'hA5 : seed[7:0];
			wr(`OFS_DATA, v);
			repeat (14) @(posedge clk);
			chk(got, v);
			rc(`OFS_LINE_STATUS, 8'h60);
		end
		wr(`OFS_INT_IDENT, 8'h08);
		rc(`OFS_INT_IDENT, 8'h01);
		wr(`OFS_INT_IDENT, 8'h01);
		rc(`OFS_INT_IDENT, 8'hC1);
		wr(`OFS_INT_IDENT, 8'h00);
		wr(`OFS_LINE_STATUS, 8'hFF);
		rc(`OFS_LINE_STATUS, 8'h60);
		wr(`OFS_MODEM_CTRL, 8'h0C);
		rc(`OFS_MODEM_CTRL, 8'h0C);
		wr(`OFS_MODEM_CTRL, 8'h08);
		wr(`OFS_INT_ENABLE, 8'h08);
		modem_in <= 4'h1;
		repeat (4) @(posedge clk);
		#1;
		chk(irq, 1'b1);
		rc(`OFS_INT_IDENT, 8'h00);
		rc(`OFS_MODEM_STATUS, 8'h11);
		rc(`OFS_MODEM_STATUS, 8'h10);
		chk(irq, 1'b0);
		wr(`OFS_INT_ENABLE, 8'h01);
		for (int i = 0; i < 3; i++) begin
			seed = xs(seed);
			v = (i == 0) ? 8'h01 : seed[7:0];
			send(v);
			chk(irq, 1'b1);
			rc(`OFS_INT_IDENT, 8'h04);
			rc(`OFS_LINE_STATUS, 8'h61);
			rc(`OFS_DATA, v);
			chk(irq, 1'b0);
			rc(`OFS_INT_IDENT, 8'h01);
		end
		send(8'h80);
		wr(`OFS_INT_ENABLE, 8'h00);
		chk(irq, 1'b0);
		rc(`OFS_DATA, 8'h80);
		finish_test();
	end
endmodule : uart_channel_regs_bench
